/* File: verilog/mrft_pkg.sv */
// constants, field layouts and carrier types of the receive fifo threshold
// block; assumes a 32-bit fifo, so every threshold counts 32-bit words
package mrft_pkg;
	// ==========================================================
	// geometry
	localparam int DATA_W = 32;
	localparam int ERR_W = 6;
	localparam int ADDR_W = 6;
	localparam int DEPTH = 64;
	localparam int CNT_W = 7;
	localparam logic [6:0] DEPTH_CNT = 7'h40;
	// ==========================================================
	// register byte offsets on the wishbone slave
	localparam logic [7:0] ADDR_ALMOST_EMPTY = 8'h00;
	localparam logic [7:0] ADDR_ALMOST_FULL = 8'h04;
	localparam logic [7:0] ADDR_SECTION_EMPTY = 8'h08;
	localparam logic [7:0] ADDR_SECTION_FULL = 8'h0c;
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
	// ==========================================================
	// reset values
	localparam logic [6:0] RST_ALMOST_EMPTY = 7'h08;
	localparam logic [6:0] RST_ALMOST_FULL = 7'h08;
	localparam logic [6:0] RST_SECTION_EMPTY = 7'h30;
	localparam logic [6:0] RST_SECTION_FULL = 7'h10;
	// ==========================================================
	// field positions
	localparam int ERR_TRUNC = 0;
	localparam int ERR_INVALID = 3;
	localparam int CTRL_DISCARD = 0;
	localparam int ST_LOW_WATER = 8;
	localparam int ST_HIGH_WATER = 9;
	localparam int ST_DATA_AVAIL = 10;
	localparam int ST_CONGESTED = 11;
	localparam int ST_STORE_FWD = 12;
	localparam int IRQ_W = 4;
	localparam int IRQ_TRUNC = 0;
	localparam int IRQ_DISCARD = 1;
	localparam int IRQ_XOFF = 2;
	localparam int IRQ_XON = 3;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [31:0] data;
		logic sop;
		logic eop;
		logic [5:0] err;
	} mrft_entry_t;
	typedef struct packed {
		logic [6:0] almost_empty;
		logic [6:0] almost_full;
		logic [6:0] section_empty;
		logic [6:0] section_full;
	} mrft_thresh_t;
endpackage

/* File: verilog/mrft_entry_store.sv */
// flip-flop storage of fifo entries, one write port, one indexed read port
// assumes the caller keeps the pointers and never writes a full store
`timescale 1ns/100ps
module mrft_entry_store (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [5:0] wr_idx,
	input wire mrft_pkg::mrft_entry_t wr_entry,
	// read port
	input wire logic [5:0] rd_idx,
	output mrft_pkg::mrft_entry_t rd_entry
);
	// ==========================================================
	// storage
	mrft_pkg::mrft_entry_t mem [mrft_pkg::DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_entry;
		end
	end

	// read is combinational; the consumer registers it
	assign rd_entry = mem[rd_idx];
endmodule

/* File: verilog/mrft_pause_req.sv */
// pause frame request sequencer driven by the section-empty level
// assumes tx_busy is high while the transmitter sends a frame
`timescale 1ns/100ps
module mrft_pause_req (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// level and transmitter state
	input wire logic congested,
	input wire logic tx_busy,
	// one-cycle requests
	output logic xoff_req,
	output logic xon_req
);
	// ==========================================================
	// state
	typedef enum logic [1:0] {
		MRFT_IDLE = 2'b00,
		MRFT_XOFF_WAIT = 2'b01,
		MRFT_CONGESTED = 2'b11,
		MRFT_XON_WAIT = 2'b10
	} mrft_pause_state_t;

	mrft_pause_state_t state;
	mrft_pause_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			MRFT_IDLE: begin
				if (congested) next_state = MRFT_XOFF_WAIT;
			end
			MRFT_XOFF_WAIT: begin
				if (!tx_busy) next_state = MRFT_CONGESTED;
			end
			MRFT_CONGESTED: begin
				if (!congested) next_state = MRFT_XON_WAIT;
			end
			MRFT_XON_WAIT: begin
				if (!tx_busy) next_state = MRFT_IDLE;
			end
			default: next_state = MRFT_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= MRFT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// requests are one cycle wide, issued only once the transmitter is idle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			xoff_req <= 1'b0;
			xon_req <= 1'b0;
		end else begin
			xoff_req <= (state == MRFT_XOFF_WAIT) && !tx_busy;
			xon_req <= (state == MRFT_XON_WAIT) && !tx_busy;
		end
	end
endmodule

/* File: verilog/mrft_rx_fifo_thresh.sv */
// receive fifo with four programmable fill thresholds and a wishbone slave
// assumes the frame writer and the user stream both run on clk
// Contract
// - unread count at or below almost-empty raises flag and stops reading
// - once an end of packet is stored, the whole frame is delivered
// - free count at or below almost-full raises the high water flag
// - almost-full with user not ready stops writes and truncates the frame
// - a truncated frame shows error bit 0 with its end of packet
// - a truncated frame also shows error bit 3, marking it invalid
// - discard on and section-full zero: errored frames are dropped
// - fill reaching nonzero section-empty requests an xoff pause frame
// - fill back below section-empty requests an xon pause frame
// - fill reaching nonzero section-full asserts data available
// - section-full zero selects store-and-forward, data available stays low
// - store-and-forward presents data once one whole frame is stored
// - thresholds count 32-bit words, since the fifo is 32 bits wide
// - a pause request waits until the current transmission completes
`timescale 1ns/100ps
module mrft_rx_fifo_thresh (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// frame writer on the network side
	input wire logic wr_valid,
	input wire logic [31:0] wr_data,
	input wire logic wr_sop,
	input wire logic wr_eop,
	input wire logic [5:0] wr_err,
	// user receive stream
	input wire logic user_recv_ready,
	output logic recv_data_valid,
	output logic [31:0] recv_data,
	output logic recv_start_of_packet,
	output logic recv_end_of_packet,
	output logic [5:0] recv_err,
	// fill flags
	output logic recv_low_water_flag,
	output logic recv_high_water_flag,
	output logic recv_data_available,
	// pause frame requests toward the transmitter
	input wire logic tx_busy,
	output logic xoff_req,
	output logic xon_req,
	// interrupt
	output logic irq
);
	// ==========================================================
	// decode helpers
	function automatic logic reg_hit(input logic [7:0] adr,
		input logic [7:0] off);
		reg_hit = (adr == off);
	endfunction

	function automatic logic [31:0] merge_sel(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) res[i*8 +: 8] = dat[i*8 +: 8];
		end
		merge_sel = res;
	endfunction

	// ==========================================================
	// registers
	mrft_pkg::mrft_thresh_t thr;
	logic discard_errored_frames;
	logic [3:0] irq_status, irq_enable;
	logic bus_req, bus_wr;

	// ==========================================================
	// fifo state
	logic [6:0] wr_ptr, commit_ptr, rd_ptr, frames_stored;
	logic dropping, in_frame;
	logic [5:0] frame_err;
	logic [6:0] fill, free, unread;
	logic store_fwd, congested, full, wr_en;
	mrft_pkg::mrft_entry_t wr_entry, rd_entry;
	logic trunc, frame_end, frame_bad, rewind, eop_commit;
	logic rd_allow, pop, eop_pop;

	// counts are in fifo entries, one 32-bit word each
	assign fill = wr_ptr - rd_ptr;
	assign free = mrft_pkg::DEPTH_CNT - fill;
	assign unread = commit_ptr - rd_ptr;
	assign full = (fill == mrft_pkg::DEPTH_CNT);
	assign store_fwd = (thr.section_full == 7'h00);

	// ==========================================================
	// fill flags
	assign recv_low_water_flag = (unread <= thr.almost_empty);
	assign recv_high_water_flag = (free <= thr.almost_full);
	// data available never rises in store-and-forward
	assign recv_data_available = !store_fwd &&
		(fill >= thr.section_full);
	// a zero section-empty threshold would hold xoff forever, so it disables
	assign congested = (thr.section_empty != 7'h00) &&
		(fill >= thr.section_empty);

	// ==========================================================
	// write side
	// truncation writes the current word as the end of the frame, so one
	// free entry is enough; a full store just drops the rest of the frame
	assign trunc = wr_valid && !dropping && !full &&
		recv_high_water_flag && !user_recv_ready;
	assign wr_en = wr_valid && !dropping && !full;
	assign frame_end = wr_en && (trunc || wr_eop);

	always_comb begin
		wr_entry.data = wr_data;
		wr_entry.sop = wr_sop;
		wr_entry.eop = wr_eop || trunc;
		wr_entry.err = wr_eop ? (frame_err | wr_err) : 6'h00;
		if (trunc) begin
			wr_entry.err = frame_err | wr_err;
			wr_entry.err[mrft_pkg::ERR_TRUNC] = 1'b1;
			wr_entry.err[mrft_pkg::ERR_INVALID] = 1'b1;
		end
	end

	assign frame_bad = |wr_entry.err;
	assign rewind = frame_end && frame_bad && store_fwd &&
		discard_errored_frames;
	assign eop_commit = frame_end && !rewind;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr <= 7'h00;
			commit_ptr <= 7'h00;
		end else if (rewind) begin
			wr_ptr <= commit_ptr;
		end else if (wr_en) begin
			wr_ptr <= wr_ptr + 7'h01;
			// store-and-forward exposes words only when the frame ends
			if (!store_fwd || frame_end) begin
				commit_ptr <= wr_ptr + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dropping <= 1'b0;
		end else if (wr_valid && dropping) begin
			dropping <= !wr_eop;
		end else if (wr_valid && (trunc || full)) begin
			dropping <= !wr_eop;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			frame_err <= 6'h00;
		end else if (wr_valid && (wr_eop || trunc)) begin
			frame_err <= 6'h00;
		end else if (wr_en) begin
			frame_err <= frame_err | wr_err;
		end
	end

	// ==========================================================
	// storage
	mrft_entry_store u_store (
		.clk(clk),
		.wr_en(wr_en),
		.wr_idx(wr_ptr[5:0]),
		.wr_entry(wr_entry),
		.rd_idx(rd_ptr[5:0]),
		.rd_entry(rd_entry)
	);

	// ==========================================================
	// read side
	// a stored end of packet overrides the almost-empty stop
	always_comb begin
		rd_allow = 1'b0;
		if (unread != 7'h00) begin
			if (store_fwd) begin
				rd_allow = (frames_stored != 7'h00);
			end else if (frames_stored != 7'h00) begin
				rd_allow = 1'b1;
			end else begin
				rd_allow = !recv_low_water_flag &&
					(in_frame || recv_data_available);
			end
		end
	end

	assign pop = rd_allow && (!recv_data_valid || user_recv_ready);
	assign eop_pop = pop && rd_entry.eop;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_ptr <= 7'h00;
			in_frame <= 1'b0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 7'h01;
			in_frame <= !rd_entry.eop;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			frames_stored <= 7'h00;
		end else if (eop_commit && !eop_pop) begin
			frames_stored <= frames_stored + 7'h01;
		end else if (eop_pop && !eop_commit) begin
			frames_stored <= frames_stored - 7'h01;
		end
	end

	// output stage; the error vector only carries meaning at end of packet
	always_ff @(posedge clk) begin
		if (!rstn) begin
			recv_data_valid <= 1'b0;
			recv_data <= 32'h0000_0000;
			recv_start_of_packet <= 1'b0;
			recv_end_of_packet <= 1'b0;
			recv_err <= 6'h00;
		end else if (pop) begin
			recv_data_valid <= 1'b1;
			recv_data <= rd_entry.data;
			recv_start_of_packet <= rd_entry.sop;
			recv_end_of_packet <= rd_entry.eop;
			recv_err <= rd_entry.eop ? rd_entry.err : 6'h00;
		end else if (user_recv_ready) begin
			recv_data_valid <= 1'b0;
		end
	end

	// ==========================================================
	// pause requests
	mrft_pause_req u_pause (
		.clk(clk),
		.rstn(rstn),
		.congested(congested),
		.tx_busy(tx_busy),
		.xoff_req(xoff_req),
		.xon_req(xon_req)
	);

	// ==========================================================
	// wishbone slave: ack one cycle after the strobe, dropped the next
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			thr.almost_empty <= mrft_pkg::RST_ALMOST_EMPTY;
			thr.almost_full <= mrft_pkg::RST_ALMOST_FULL;
			thr.section_empty <= mrft_pkg::RST_SECTION_EMPTY;
			thr.section_full <= mrft_pkg::RST_SECTION_FULL;
		end else if (bus_wr) begin
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_ALMOST_EMPTY)) begin
				thr.almost_empty <= 7'(merge_sel(
					{25'h0, thr.almost_empty}, wb_dat_i, wb_sel_i));
			end
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_ALMOST_FULL)) begin
				thr.almost_full <= 7'(merge_sel(
					{25'h0, thr.almost_full}, wb_dat_i, wb_sel_i));
			end
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_SECTION_EMPTY)) begin
				thr.section_empty <= 7'(merge_sel(
					{25'h0, thr.section_empty}, wb_dat_i, wb_sel_i));
			end
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_SECTION_FULL)) begin
				thr.section_full <= 7'(merge_sel(
					{25'h0, thr.section_full}, wb_dat_i, wb_sel_i));
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			discard_errored_frames <= 1'b0;
			irq_enable <= 4'h0;
		end else if (bus_wr && wb_sel_i[0]) begin
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_CONTROL)) begin
				discard_errored_frames <= wb_dat_i[mrft_pkg::CTRL_DISCARD];
			end
			if (reg_hit(wb_adr_i, mrft_pkg::ADDR_IRQ_ENABLE)) begin
				irq_enable <= wb_dat_i[3:0];
			end
		end
	end

	// ==========================================================
	// interrupt status: a new event wins over a clear in the same cycle
	logic [3:0] irq_event;
	logic [3:0] irq_clear;

	always_comb begin
		irq_event = 4'h0;
		irq_event[mrft_pkg::IRQ_TRUNC] = trunc;
		irq_event[mrft_pkg::IRQ_DISCARD] = rewind;
		irq_event[mrft_pkg::IRQ_XOFF] = xoff_req;
		irq_event[mrft_pkg::IRQ_XON] = xon_req;
	end

	assign irq_clear = (bus_wr && wb_sel_i[0] &&
		reg_hit(wb_adr_i, mrft_pkg::ADDR_IRQ_CLEAR)) ? wb_dat_i[3:0] : 4'h0;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_status <= 4'h0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_event;
		end
	end

	assign irq = |(irq_status & irq_enable);

	// ==========================================================
	// read data; unmapped and write-only offsets read zero
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			mrft_pkg::ADDR_ALMOST_EMPTY: next_rdata[6:0] = thr.almost_empty;
			mrft_pkg::ADDR_ALMOST_FULL: next_rdata[6:0] = thr.almost_full;
			mrft_pkg::ADDR_SECTION_EMPTY: next_rdata[6:0] = thr.section_empty;
			mrft_pkg::ADDR_SECTION_FULL: next_rdata[6:0] = thr.section_full;
			mrft_pkg::ADDR_CONTROL: begin
				next_rdata[mrft_pkg::CTRL_DISCARD] = discard_errored_frames;
			end
			mrft_pkg::ADDR_STATUS: begin
				next_rdata[6:0] = fill;
				next_rdata[mrft_pkg::ST_LOW_WATER] = recv_low_water_flag;
				next_rdata[mrft_pkg::ST_HIGH_WATER] = recv_high_water_flag;
				next_rdata[mrft_pkg::ST_DATA_AVAIL] = recv_data_available;
				next_rdata[mrft_pkg::ST_CONGESTED] = congested;
				next_rdata[mrft_pkg::ST_STORE_FWD] = store_fwd;
			end
			mrft_pkg::ADDR_IRQ_STATUS: next_rdata[3:0] = irq_status;
			mrft_pkg::ADDR_IRQ_ENABLE: next_rdata[3:0] = irq_enable;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end
endmodule

/* File: testbench/mrft_asserts.sv */
// checker of the receive fifo threshold block, top ports only
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module mrft_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// user stream
	input wire logic user_recv_ready,
	input wire logic recv_data_valid,
	input wire logic [31:0] recv_data,
	input wire logic recv_end_of_packet,
	input wire logic [5:0] recv_err,
	// pause requests
	input wire logic tx_busy,
	input wire logic xoff_req,
	input wire logic xon_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// xoff and xon must alternate, so remember the last one sent
	logic paused;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			paused <= 1'b0;
		end else if (xoff_req) begin
			paused <= 1'b1;
		end else if (xon_req) begin
			paused <= 1'b0;
		end
	end
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
	a_bus_answer: assert property (s_req |=> s_ans)
		else $error("bus answer missing or too long");
	a_trunc_invalid: assert property (
		recv_data_valid && recv_err[0] |-> recv_err[3] && recv_end_of_packet)
		else $error("truncated word lacks invalid mark or end");
	a_err_on_eop: assert property (
		recv_data_valid && !recv_end_of_packet |-> recv_err == 6'h00)
		else $error("error bits away from end of packet");
	a_word_holds: assert property (
		recv_data_valid && !user_recv_ready |=>
		recv_data_valid && $stable(recv_data))
		else $error("word withdrawn before taken");
	a_xoff_pulse: assert property (xoff_req |=> !xoff_req)
		else $error("xoff request longer than a cycle");
	a_xoff_order: assert property (xoff_req |-> !paused && !xon_req)
		else $error("xoff request out of order");
	a_xon_order: assert property (xon_req |-> paused)
		else $error("xon request without xoff");
	a_pause_waits: assert property (
		xoff_req || xon_req |-> !$past(tx_busy))
		else $error("pause request during transmission");
endmodule
bind mrft_rx_fifo_thresh mrft_asserts chk_u (.clk, .rstn, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .user_recv_ready, .recv_data_valid, .recv_data,
	.recv_end_of_packet, .recv_err, .tx_busy, .xoff_req, .xon_req);

/* File: testbench/mrft_user_model.sv */
// user application model on the receive stream
// assumes it shares clk and rstn with the block
`timescale 1ns/100ps
module mrft_user_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// behaviour select
	input wire logic hold,
	input wire logic slow,
	// stream
	output logic user_recv_ready
);
	logic [15:0] seq;
	// held low it lets the fifo fill up to the truncation point
	always_ff @(posedge clk) begin
		if (!rstn) begin
			seq <= 16'h5a3c;
			user_recv_ready <= 1'b0;
		end else begin
			seq <= {seq[14:0], seq[15] ^ seq[13] ^ seq[12] ^ seq[10]};
			user_recv_ready <= !hold && (!slow || seq[0]);
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench of the receive fifo threshold block
// assumes the checker binds itself and the user model drives ready
`timescale 1ns/100ps
module tb_top;
	logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, wr_data, recv_data, rdat;
	logic wr_valid, wr_sop, wr_eop, user_recv_ready, recv_data_valid;
	logic [5:0] wr_err, recv_err, acc;
	logic recv_start_of_packet, recv_end_of_packet, recv_low_water_flag;
	logic recv_high_water_flag, recv_data_available, tx_busy, xoff_req;
	logic xon_req, irq, hold, slow, sf_mode, dropping, pend_v;
	logic [15:0] seed;
	int n_fail, compares, n_xoff, n_xon, i, len;
	mrft_pkg::mrft_entry_t exp_q[$], tmp_q[$], pend;
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24};
	logic [6:0] rv[6] = '{7'h08, 7'h08, 7'h30, 7'h10, 7'h00, 7'h00};

	mrft_rx_fifo_thresh dut_u (.clk, .rstn, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.wr_valid, .wr_data, .wr_sop, .wr_eop, .wr_err, .user_recv_ready,
		.recv_data_valid, .recv_data, .recv_start_of_packet,
		.recv_end_of_packet, .recv_err, .recv_low_water_flag,
		.recv_high_water_flag, .recv_data_available, .tx_busy, .xoff_req,
		.xon_req, .irq);
	mrft_user_model model_u (.clk, .rstn, .hold, .slow, .user_recv_ready);

	// ==========
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [5:0] exp_err(input logic [5:0] a, input logic t);
		return t ? (a | 6'h09) : a;
	endfunction
	task automatic chk(input logic [39:0] got, exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		chk(40'(n < 50), 40'h1, "bus answer");
	endtask
	// expected contents, settled at the edge that takes each word
	task automatic take_prev();
		logic tr;
		tr = !dropping && recv_high_water_flag && !user_recv_ready;
		if (pend_v && !dropping) begin
			acc = (pend.sop ? 6'h00 : acc) | pend.err;
			dropping = tr && !pend.eop;
			pend.eop = pend.eop | tr;
			pend.err = pend.eop ? exp_err(acc, tr) : 6'h00;
			if (!sf_mode) begin
				exp_q.push_back(pend);
			end else begin
				tmp_q.push_back(pend);
			end
			if (sf_mode && pend.eop) begin
				if (pend.err == 6'h00) begin
					exp_q = {exp_q, tmp_q};
				end
				tmp_q.delete();
			end
		end else if (pend_v && pend.eop) begin
			dropping = 1'b0;
		end
		pend_v = 1'b0;
	endtask
	task automatic put_word(input logic s, e, input logic [5:0] r);
		@(posedge clk);
		take_prev();
		seed = lfsr(seed);
		pend = '{data: {seed, ~seed}, sop: s, eop: e, err: r};
		pend_v = 1'b1;
		wr_valid <= 1'b1;
		wr_data <= pend.data;
		wr_sop <= s;
		wr_eop <= e;
		wr_err <= r;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			take_prev();
			wr_valid <= 1'b0;
		end
	endtask
	task automatic drain();
		for (int k = 0; k < 600 && exp_q.size() != 0; k++) @(posedge clk);
	endtask

	// ==========
	// clock, watchdog and receive monitor
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("wrong value at %0t ns: run hung", $time);
		complete_run();
	end
	always @(posedge clk) begin
		if (xoff_req === 1'b1) n_xoff++;
		if (xon_req === 1'b1) n_xon++;
		if (rstn && recv_data_valid && user_recv_ready) begin
			if (exp_q.size() == 0) begin
				chk(40'h1, 40'h0, "unexpected word");
			end else begin
				chk({recv_data, recv_start_of_packet, recv_end_of_packet,
					recv_err}, exp_q.pop_front(), "received word");
			end
		end
	end

	// ==========
	// tests
	initial begin
		{rstn, wb_cyc_i, wb_stb_i, wb_we_i, wr_valid, wr_sop, wr_eop} = 7'h00;
		{wb_adr_i, wb_dat_i, wr_data, wr_err, tx_busy} = 79'h0;
		{hold, slow, sf_mode, dropping, pend_v, acc} = 11'h000;
		wb_sel_i = 4'hf;
		seed = 16'h89cb;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		foreach (ra[k]) begin
			wb(1'b0, ra[k], 32'h0);
			chk(40'(rdat), 40'(rv[k]), "reset value");
		end
		$display("test reset values done");
		hold <= 1'b1;
		tx_busy <= 1'b1;
		for (i = 0; i < 10; i++) put_word(i == 0, 1'b0, 6'h00);
		idle(2);
		chk(40'(recv_data_available), 40'h0, "fill 10");
		chk(40'(recv_low_water_flag), 40'h0, "above low water");
		wb(1'b0, mrft_pkg::ADDR_STATUS, 32'h0);
		chk(40'(rdat), 40'h0a, "status fill in words");
		for (i = 0; i < 40; i++) put_word(1'b0, 1'b0, 6'h00);
		idle(3);
		chk(40'(recv_data_available), 40'h1, "section full");
		chk(40'(n_xoff), 40'h0, "pause while busy");
		tx_busy <= 1'b0;
		idle(4);
		chk(40'(n_xoff), 40'h1, "xoff requested");
		for (i = 0; i < 30 && !dropping; i++) put_word(1'b0, 1'b0, 6'h00);
		chk(40'(recv_high_water_flag), 40'h1, "high water");
		put_word(1'b0, 1'b0, 6'h02);
		put_word(1'b0, 1'b1, 6'h00);
		idle(2);
		chk(40'(irq), 40'h0, "interrupt masked");
		wb(1'b1, mrft_pkg::ADDR_IRQ_ENABLE, 32'hf);
		idle(1);
		chk(40'(irq), 40'h1, "interrupt raised");
		hold <= 1'b0;
		drain();
		chk(40'(exp_q.size()), 40'h0, "truncated frame out");
		idle(6);
		chk(40'({n_xon, recv_low_water_flag}), 40'h3, "xon, empty");
		wb(1'b0, mrft_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(40'(rdat), 40'hd, "event status");
		wb(1'b1, mrft_pkg::ADDR_IRQ_CLEAR, 32'hf);
		idle(1);
		chk(40'(irq), 40'h0, "interrupt cleared");
		$display("test cut-through truncation done");
		wb(1'b1, mrft_pkg::ADDR_SECTION_FULL, 32'h0);
		wb(1'b1, mrft_pkg::ADDR_CONTROL, 32'h1);
		sf_mode = 1'b1;
		hold <= 1'b1;
		for (i = 0; i < 4; i++) put_word(i == 0, 1'b0, 6'h00);
		idle(4);
		chk(40'(recv_data_valid), 40'h0, "partial");
		chk(40'(recv_data_available), 40'h0, "sf no avail");
		wb(1'b0, mrft_pkg::ADDR_STATUS, 32'h0);
		chk(40'(rdat), 40'h1104, "sf status");
		put_word(1'b0, 1'b1, 6'h00);
		idle(4);
		chk(40'(recv_data_valid), 40'h1, "whole frame shown");
		hold <= 1'b0;
		slow <= 1'b1;
		frame_words(3, 6'h04);
		for (int f = 0; f < 40; f++) begin
			seed = lfsr(seed);
			len = 1 + int'(seed[3:0]) % 6;
			frame_words(len, seed[6:4] == 3'h0 ? 6'h04 : 6'h00);
		end
		idle(2);
		chk(40'(recv_data_available), 40'h0, "no early start");
		drain();
		chk(40'(exp_q.size()), 40'h0, "errored frames dropped");
		wb(1'b0, mrft_pkg::ADDR_IRQ_STATUS, 32'h0);
		chk(40'(rdat[1]), 40'h1, "discard event");
		$display("test store-and-forward done");
		complete_run();
	end
	task automatic frame_words(input int n, input logic [5:0] r);
		for (int k = 0; k < n; k++) begin
			put_word(k == 0, k == n - 1, k == n - 1 ? r : 6'h00);
		end
		idle(1);
	endtask
endmodule
